// ### hw/icda_consts.svh
`ifndef ICDA_CONSTS_SVH
`define ICDA_CONSTS_SVH

`define ICDA_CODE_W        4
`define ICDA_BLK_W         3
`define ICDA_ADDR_W        11
`define ICDA_DATA_W        8
`define ICDA_CNT_W         4
`define ICDA_OFS_DELAY_A   11'h0C0
`define ICDA_OFS_DELAY_B   11'h0C1
`define ICDA_OFS_DELAY_C   11'h0C2
`define ICDA_OFS_COUNTER   11'h0C3
`define ICDA_RST_DELAY_A   8'h64
`define ICDA_RST_DELAY_B   8'h32
`define ICDA_RST_DELAY_C   8'hFF
`define ICDA_RST_COUNTER   8'h96
`define ICDA_LOCK_LIMIT    11'h0C0
`define ICDA_LOCKED_BYTE   8'hFF
`define ICDA_OSC_DIV       10
`define ICDA_PREDIV_W      2
`define ICDA_DELAY_UNITS   3

`endif

// ### hw/icda_pkg.sv
package icda_pkg;

    typedef enum logic [3:0]
    {
        S_IDLE,
        S_CTRL,
        S_CTRL_ACK,
        S_WADDR,
        S_WADDR_ACK,
        S_WDATA,
        S_WDATA_ACK,
        S_RDATA,
        S_RDATA_ACK,
        S_WAIT
    } icda_state_t;

    typedef logic [7:0] icda_byte_t;

endpackage

// ### hw/icda_mem_if.sv
`timescale 1ns/10ps
`default_nettype none

interface icda_mem_if
#(
    parameter int AW = 11,
    parameter int DW = 8
);
    logic          wr_en;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;

    modport ctrl
    (
        output wr_en,
        output addr,
        output wdata,
        input  rdata
    );

    modport store
    (
        input  wr_en,
        input  addr,
        input  wdata,
        output rdata
    );
endinterface

`default_nettype wire

// ### hw/icda_mem.sv
`timescale 1ns/10ps
`default_nettype none

module icda_mem
#(
    parameter int AW = 11,
    parameter int DW = 8
)
(
    input wire logic      i_clock,
    icda_mem_if.store     mem
);
    logic [DW-1:0] cells [0:(1<<AW)-1];

    // configuration cells carry no reset, only the presets do
    always_ff @(posedge i_clock)
    begin
        if (mem.wr_en)
        begin
            cells[mem.addr] <= mem.wdata;
        end
    end

    always_ff @(posedge i_clock)
    begin
        mem.rdata <= cells[mem.addr];
    end
endmodule

`default_nettype wire

// ### hw/icda_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "icda_consts.svh"

module icda_top
#(
    parameter int OSC_DIV = `ICDA_OSC_DIV,
    parameter int UNITS   = `ICDA_DELAY_UNITS
)
(
    input  wire logic                      i_clock,
    input  wire logic                      i_rst,
    input  wire logic                      i_scl,
    input  wire logic                      i_sda,
    output logic                           o_sda,
    output logic                           o_sda_oe_n,
    input  wire logic [`ICDA_CODE_W-1:0]   i_control_code,
    input  wire logic                      i_lock_read,
    input  wire logic                      i_lock_write,
    input  wire logic [`ICDA_PREDIV_W-1:0] i_osc_prediv,
    input  wire logic [UNITS-1:0]          i_delay_trig,
    output logic      [UNITS-1:0]          o_delay_out,
    input  wire logic                      i_counter_enable,
    output logic                           o_event_counter_pulse,
    output icda_pkg::icda_state_t          o_state
);
    import icda_pkg::*;

    localparam int AW = `ICDA_ADDR_W;

    function automatic logic is_locked(input logic [AW-1:0] a);
        is_locked = (a < `ICDA_LOCK_LIMIT);
    endfunction

    function automatic logic is_preset(input logic [AW-1:0] a);
        is_preset = (a >= `ICDA_OFS_DELAY_A) && (a <= `ICDA_OFS_COUNTER);
    endfunction

    icda_mem_if #(.AW(AW), .DW(`ICDA_DATA_W)) mem ();

    icda_mem #(.AW(AW), .DW(`ICDA_DATA_W)) u_mem
    (
        .i_clock (i_clock),
        .mem     (mem.store)
    );

    // pin synchronisers: a level counts once stages two and three agree
    logic [2:0] scl_pipe;
    logic [2:0] sda_pipe;
    logic       scl_q;
    logic       sda_q;
    logic       scl_prev;
    logic       sda_prev;

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            scl_pipe <= 3'h7;
            sda_pipe <= 3'h7;
        end
        else
        begin
            scl_pipe <= {scl_pipe[1:0], i_scl};
            sda_pipe <= {sda_pipe[1:0], i_sda};
        end
    end

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            scl_q    <= 1'b1;
            sda_q    <= 1'b1;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end
        else
        begin
            if (scl_pipe[1] == scl_pipe[2])
            begin
                scl_q <= scl_pipe[2];
            end
            if (sda_pipe[1] == sda_pipe[2])
            begin
                sda_q <= sda_pipe[2];
            end
            scl_prev <= scl_q;
            sda_prev <= sda_q;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    assign scl_rise  = scl_q & ~scl_prev;
    assign scl_fall  = ~scl_q & scl_prev;
    assign start_det = scl_q & scl_prev & sda_prev & ~sda_q;
    assign stop_det  = scl_q & scl_prev & ~sda_prev & sda_q;

    icda_state_t            state;
    logic [`ICDA_CNT_W-1:0] bit_cnt;
    icda_byte_t             shift_in;
    icda_byte_t             shift_out;
    logic [`ICDA_BLK_W-1:0] blk;
    logic                   rw;
    logic [AW-1:0]          ptr;
    logic                   sda_drive_low;
    icda_byte_t             preset [0:3];
    icda_byte_t             rd_byte;
    logic                   byte_done;
    logic                   code_match;
    logic                   wr_commit;

    assign byte_done  = scl_fall && (bit_cnt == 4'h8);
    assign code_match = (shift_in[7:4] == i_control_code);
    // store happens on the same edge that starts driving the acknowledge
    assign wr_commit  = byte_done && (state == S_WDATA);

    always_comb
    begin
        if (i_lock_read && is_locked(ptr))
        begin
            rd_byte = `ICDA_LOCKED_BYTE;
        end
        else if (is_preset(ptr))
        begin
            rd_byte = preset[ptr[1:0]];
        end
        else
        begin
            rd_byte = mem.rdata;
        end
    end

    assign mem.addr  = ptr;
    assign mem.wdata = shift_in;
    assign mem.wr_en = wr_commit && !(i_lock_write && is_locked(ptr));

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            state         <= S_IDLE;
            bit_cnt       <= 4'h0;
            shift_in      <= 8'h00;
            shift_out     <= 8'h00;
            blk           <= 3'h0;
            rw            <= 1'b0;
            ptr           <= 11'h000;
            sda_drive_low <= 1'b0;
        end
        else if (start_det)
        begin
            // repeated start: pending write dropped, pointer left alone
            state         <= S_CTRL;
            bit_cnt       <= 4'h0;
            sda_drive_low <= 1'b0;
        end
        else if (stop_det)
        begin
            state         <= S_IDLE;
            sda_drive_low <= 1'b0;
        end
        else if (scl_rise)
        begin
            case (state)
                S_CTRL, S_WADDR, S_WDATA:
                begin
                    shift_in <= {shift_in[6:0], sda_q};
                    bit_cnt  <= bit_cnt + 4'h1;
                end
                S_RDATA_ACK:
                begin
                    if (sda_q)
                    begin
                        state <= S_WAIT;
                    end
                    else
                    begin
                        ptr <= ptr + 11'h001;
                    end
                end
                default:
                begin
                end
            endcase
        end
        else if (scl_fall)
        begin
            case (state)
                S_CTRL:
                begin
                    if (byte_done)
                    begin
                        if (code_match)
                        begin
                            blk           <= shift_in[3:1];
                            rw            <= shift_in[0];
                            sda_drive_low <= 1'b1;
                            state         <= S_CTRL_ACK;
                        end
                        else
                        begin
                            state <= S_WAIT;
                        end
                    end
                end
                S_CTRL_ACK:
                begin
                    if (rw)
                    begin
                        // first data bit goes out on the ack's falling edge
                        sda_drive_low <= ~rd_byte[7];
                        shift_out     <= {rd_byte[6:0], 1'b0};
                        bit_cnt       <= 4'h1;
                        state         <= S_RDATA;
                    end
                    else
                    begin
                        sda_drive_low <= 1'b0;
                        bit_cnt       <= 4'h0;
                        state         <= S_WADDR;
                    end
                end
                S_WADDR:
                begin
                    if (byte_done)
                    begin
                        ptr           <= {blk, shift_in};
                        sda_drive_low <= 1'b1;
                        state         <= S_WADDR_ACK;
                    end
                end
                S_WADDR_ACK:
                begin
                    sda_drive_low <= 1'b0;
                    bit_cnt       <= 4'h0;
                    state         <= S_WDATA;
                end
                S_WDATA:
                begin
                    if (byte_done)
                    begin
                        sda_drive_low <= 1'b1;
                        state         <= S_WDATA_ACK;
                    end
                end
                S_WDATA_ACK:
                begin
                    // only single byte writes: further bytes are ignored
                    sda_drive_low <= 1'b0;
                    state         <= S_WAIT;
                end
                S_RDATA:
                begin
                    if (bit_cnt == 4'h8)
                    begin
                        sda_drive_low <= 1'b0;
                        state         <= S_RDATA_ACK;
                    end
                    else
                    begin
                        sda_drive_low <= ~shift_out[7];
                        shift_out     <= {shift_out[6:0], 1'b0};
                        bit_cnt       <= bit_cnt + 4'h1;
                    end
                end
                S_RDATA_ACK:
                begin
                    sda_drive_low <= ~rd_byte[7];
                    shift_out     <= {rd_byte[6:0], 1'b0};
                    bit_cnt       <= 4'h1;
                    state         <= S_RDATA;
                end
                default:
                begin
                    sda_drive_low <= 1'b0;
                end
            endcase
        end
    end

    assign o_sda      = 1'b0;
    assign o_sda_oe_n = ~sda_drive_low;
    assign o_state    = state;

    // presets are writable even when the lower range is write-locked
    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            preset[0] <= `ICDA_RST_DELAY_A;
            preset[1] <= `ICDA_RST_DELAY_B;
            preset[2] <= `ICDA_RST_DELAY_C;
            preset[3] <= `ICDA_RST_COUNTER;
        end
        else if (wr_commit && is_preset(ptr))
        begin
            preset[ptr[1:0]] <= shift_in;
        end
    end

    // oscillator: base divider then selectable pre-divider
    logic [$clog2(OSC_DIV+1)-1:0] base_cnt;
    logic                         base_tick;
    logic [7:0]                   pre_cnt;
    logic [7:0]                   pre_mask;
    logic                         tick;

    assign base_tick = (base_cnt == ($clog2(OSC_DIV+1))'(OSC_DIV - 1));
    assign pre_mask  = (8'h01 << i_osc_prediv) - 8'h01;
    assign tick      = base_tick && ((pre_cnt & pre_mask) == 8'h00);

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            base_cnt <= '0;
            pre_cnt  <= 8'h00;
        end
        else if (base_tick)
        begin
            base_cnt <= '0;
            pre_cnt  <= pre_cnt + 8'h01;
        end
        else
        begin
            base_cnt <= base_cnt + 1'b1;
        end
    end

    // delay units: trigger is not aligned to tick, hence up to one period extra
    logic [8:0] dly_cnt [0:UNITS-1];

    genvar g;
    generate
        for (g = 0; g < UNITS; g++)
        begin : g_dly
            always_ff @(posedge i_clock or posedge i_rst)
            begin
                if (i_rst)
                begin
                    dly_cnt[g]     <= 9'h000;
                    o_delay_out[g] <= 1'b0;
                end
                else if (!i_delay_trig[g])
                begin
                    // first tick only closes the partial period, so preset+1 full ones follow
                    dly_cnt[g]     <= {1'b0, preset[g]} + 9'h002;
                    o_delay_out[g] <= 1'b0;
                end
                else if (tick && !o_delay_out[g])
                begin
                    if (dly_cnt[g] == 9'h001)
                    begin
                        o_delay_out[g] <= 1'b1;
                    end
                    dly_cnt[g] <= dly_cnt[g] - 9'h001;
                end
            end
        end
    endgenerate

    // event counter: one pulse every preset+1 ticks while enabled
    logic [8:0] evt_cnt;

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            evt_cnt               <= 9'h000;
            o_event_counter_pulse <= 1'b0;
        end
        else
        begin
            o_event_counter_pulse <= 1'b0;
            if (!i_counter_enable)
            begin
                evt_cnt <= 9'h000;
            end
            else if (tick)
            begin
                if (evt_cnt == {1'b0, preset[3]})
                begin
                    evt_cnt               <= 9'h000;
                    o_event_counter_pulse <= 1'b1;
                end
                else
                begin
                    evt_cnt <= evt_cnt + 9'h001;
                end
            end
        end
    end

    // helper: ticks seen by delay unit a since its trigger rose
    logic [8:0] ticks_a;

    always_ff @(posedge i_clock or posedge i_rst)
    begin
        if (i_rst)
        begin
            ticks_a <= 9'h000;
        end
        else if (!i_delay_trig[0])
        begin
            ticks_a <= 9'h000;
        end
        else if (tick && !o_delay_out[0])
        begin
            ticks_a <= ticks_a + 9'h001;
        end
    end

    ctrl_ack_a: assert property (@(posedge i_clock) disable iff (i_rst)
        (byte_done && state == S_CTRL && code_match && !start_det && !stop_det)
        |=> (sda_drive_low && state == S_CTRL_ACK))
        else $error("matching control byte not acknowledged");

    code_nack_a: assert property (@(posedge i_clock) disable iff (i_rst)
        (byte_done && state == S_CTRL && !code_match && !start_det && !stop_det)
        |=> (!sda_drive_low && state == S_WAIT))
        else $error("foreign control code was acknowledged");

    ptr_form_a: assert property (@(posedge i_clock) disable iff (i_rst)
        (byte_done && state == S_WADDR && !start_det && !stop_det)
        |=> (ptr == {$past(blk), $past(shift_in)}))
        else $error("pointer not block bits over word address");

    write_commit_a: assert property (@(posedge i_clock) disable iff (i_rst)
        mem.wr_en |=> (sda_drive_low && state == S_WDATA_ACK))
        else $error("store not aligned with data acknowledge");

    rstart_keep_a: assert property (@(posedge i_clock) disable iff (i_rst)
        (start_det && state == S_WDATA)
        |-> !mem.wr_en ##1 (state == S_CTRL && ptr == $past(ptr)))
        else $error("repeated start disturbed write pointer");

    read_first_a: assert property (@(posedge i_clock) disable iff (i_rst)
        (scl_fall && state == S_CTRL_ACK && rw && !start_det)
        |=> (state == S_RDATA && sda_drive_low == !$past(rd_byte[7])))
        else $error("read byte msb not driven after acknowledge");

    delay_len_a: assert property (@(posedge i_clock) disable iff (i_rst)
        $rose(o_delay_out[0]) |-> (ticks_a == {1'b0, preset[0]} + 9'h002))
        else $error("delay length differs from preset plus one");

    prediv_gap_a: assert property (@(posedge i_clock) disable iff (i_rst)
        (tick && i_osc_prediv != 2'h0 && $stable(i_osc_prediv)) |=> !tick [*3])
        else $error("pre-divider did not spread ticks");

    preset_rst_a: assert property (@(posedge i_clock)
        $fell(i_rst) |-> (preset[0] == `ICDA_RST_DELAY_A && preset[1] == `ICDA_RST_DELAY_B
        && preset[2] == `ICDA_RST_DELAY_C && preset[3] == `ICDA_RST_COUNTER))
        else $error("preset reset values wrong");

    lock_read_a: assert property (@(posedge i_clock) disable iff (i_rst)
        (i_lock_read && ptr < `ICDA_LOCK_LIMIT) |-> (rd_byte == `ICDA_LOCKED_BYTE))
        else $error("locked byte readable");
endmodule

`default_nettype wire

// ### test/icda_bus_master.sv
`timescale 1ns/10ps
`default_nettype none

module icda_bus_master
#(
    parameter int HALF = 12
)
(
    input  wire logic i_clock,
    input  wire logic i_sda_line,
    output logic      o_scl,
    output logic      o_sda_low
);
    import icda_pkg::*;

    initial
    begin
        o_scl     = 1'b1;
        o_sda_low = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask

    // also serves as repeated start; the wait lets the target let go of its ack first
    task automatic start_cond();
        o_sda_low = 1'b0;
        wait_clk(HALF / 2);
        o_scl = 1'b1;
        wait_clk(HALF);
        o_sda_low = 1'b1;
        wait_clk(HALF);
        o_scl = 1'b0;
    endtask

    task automatic stop_cond();
        wait_clk(HALF / 2);
        o_sda_low = 1'b1;
        wait_clk(HALF / 2);
        o_scl = 1'b1;
        wait_clk(HALF);
        o_sda_low = 1'b0;
        wait_clk(HALF);
    endtask

    // data moves only while scl is low; sampled late in the high phase
    task automatic bit_slot(input logic b, output logic seen);
        wait_clk(HALF / 2);
        o_sda_low = ~b;
        wait_clk(HALF / 2);
        o_scl = 1'b1;
        wait_clk(HALF);
        seen = i_sda_line;
        o_scl = 1'b0;
    endtask

    task automatic send_byte(input icda_byte_t b, output logic acked);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_slot(b[i], s);
        bit_slot(1'b1, s);
        acked = ~s;
    endtask

    task automatic recv_byte(input logic nack, output icda_byte_t b);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_slot(1'b1, b[i]);
        bit_slot(nack, s);
    endtask

    function automatic icda_byte_t ctrl(input logic [3:0] code, input logic [10:0] a,
                                        input logic rd);
        return {code, a[10:8], rd};
    endfunction

    // data byte is sent even after a refused control byte, the target must ignore it
    task automatic write_cmd(input logic [3:0] code, input logic [10:0] a,
                             input icda_byte_t d, output logic [2:0] acks);
        start_cond();
        send_byte(ctrl(code, a, 1'b0), acks[2]);
        send_byte(a[7:0], acks[1]);
        send_byte(d, acks[0]);
        stop_cond();
    endtask

    task automatic read_cmd(input logic [3:0] code, input logic [10:0] a,
                            output icda_byte_t d, output logic [2:0] acks);
        start_cond();
        send_byte(ctrl(code, a, 1'b0), acks[2]);
        send_byte(a[7:0], acks[1]);
        start_cond();
        send_byte(ctrl(code, a, 1'b1), acks[0]);
        recv_byte(1'b1, d);
        stop_cond();
    endtask
endmodule

`default_nettype wire

// ### test/i2c_config_delay_access_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module i2c_config_delay_access_tb_top;
    import icda_pkg::*;

    localparam int         OSC_DIV = 2;
    localparam logic [3:0] CODE    = 4'hA;

    logic        clock;
    logic        rst;
    logic        scl;
    logic        sda_low;
    logic        sda_line;
    logic        sda_drv;
    logic        sda_oe_n;
    logic        lock_rd;
    logic        lock_wr;
    logic [1:0]  prediv;
    logic [2:0]  trig;
    logic [2:0]  dly_out;
    logic        cnt_en;
    logic        cnt_pulse;
    icda_state_t state;
    logic [2:0]  acks;
    icda_byte_t  rst_vals [4] = '{8'h64, 8'h32, 8'hFF, 8'h96};
    int          fails;
    int          n_compared;

    // pull-up: released line reads high
    assign sda_line = ~sda_low & (sda_oe_n | sda_drv);

    icda_top #(.OSC_DIV(OSC_DIV)) u_dut
    (
        .i_clock               (clock),
        .i_rst                 (rst),
        .i_scl                 (scl),
        .i_sda                 (sda_line),
        .o_sda                 (sda_drv),
        .o_sda_oe_n            (sda_oe_n),
        .i_control_code        (CODE),
        .i_lock_read           (lock_rd),
        .i_lock_write          (lock_wr),
        .i_osc_prediv          (prediv),
        .i_delay_trig          (trig),
        .o_delay_out           (dly_out),
        .i_counter_enable      (cnt_en),
        .o_event_counter_pulse (cnt_pulse),
        .o_state               (state)
    );

    icda_bus_master u_master
    (
        .i_clock    (clock),
        .i_sda_line (sda_line),
        .o_scl      (scl),
        .o_sda_low  (sda_low)
    );

    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic print_verdict();
        if (fails == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [10:0] a, input icda_byte_t d);
        u_master.write_cmd(CODE, a, d, acks);
        check("write acks", 32'(3'b111), 32'(acks));
    endtask

    task automatic rd_chk(input logic [10:0] a, input icda_byte_t exp);
        icda_byte_t d;
        u_master.read_cmd(CODE, a, d, acks);
        check("read acks", 32'(3'b111), 32'(acks));
        check("read data", 32'(exp), 32'(d));
    endtask

    task automatic step();
        @(posedge clock);
        #1;
    endtask

    // lower bound is preset+1 ticks; slack above covers jitter and pin registers
    task automatic delay_chk(input int u, input int p, input int t);
        int n;
        n = 0;
        step();
        trig[u] = 1'b1;
        while (dly_out[u] !== 1'b1 && n < 4000)
        begin
            step();
            n++;
        end
        check("delay low bound", 1, 32'(n >= (p + 1) * t));
        check("delay high bound", 1, 32'(n <= (p + 2) * t + 4));
        trig[u] = 1'b0;
        repeat (2) step();
        check("delay cleared", 0, 32'(dly_out[u]));
    endtask

    task automatic counter_chk(input int p, input int t);
        int n;
        n = 0;
        cnt_en = 1'b1;
        while (cnt_pulse !== 1'b1 && n < 4000)
        begin
            step();
            n++;
        end
        n = 0;
        do
        begin
            step();
            n++;
        end
        while (cnt_pulse !== 1'b1 && n < 4000);
        check("counter period", 32'((p + 1) * t), 32'(n));
        cnt_en = 1'b0;
    endtask

    initial
    begin
        fails      = 0;
        n_compared = 0;
        rst        = 1'b1;
        lock_rd    = 1'b0;
        lock_wr    = 1'b0;
        prediv     = 2'h0;
        trig       = 3'h0;
        cnt_en     = 1'b0;
        repeat (4) step();
        rst = 1'b0;
        repeat (4) step();
        for (int i = 0; i < 4; i++)
            rd_chk(11'(11'h0C0 + i), rst_vals[i]);
        wr(11'h512, 8'hA5);
        wr(11'h012, 8'h3C);
        rd_chk(11'h512, 8'hA5);
        rd_chk(11'h012, 8'h3C);
        u_master.write_cmd(4'h5, 11'h012, 8'hEE, acks);
        check("foreign code acks", 0, 32'(acks));
        check("state after refusal", 32'(S_IDLE), 32'(state));
        rd_chk(11'h012, 8'h3C);
        lock_wr = 1'b1;
        wr(11'h012, 8'h77);
        lock_wr = 1'b0;
        rd_chk(11'h012, 8'h3C);
        lock_rd = 1'b1;
        rd_chk(11'h012, 8'hFF);
        lock_rd = 1'b0;
        for (int i = 0; i < 4; i++)
            wr(11'(11'h0C0 + i), 8'(i + 2));
        rd_chk(11'h0C3, 8'h05);
        for (int sel = 0; sel < 2; sel++)
        begin
            prediv = 2'(sel);
            for (int u = 0; u < 3; u++)
                delay_chk(u, u + 2, OSC_DIV << sel);
            counter_chk(5, OSC_DIV << sel);
        end
        print_verdict();
    end

    // whole run needs about 1.6 ms
    initial
    begin
        #8000000;
        fails++;
        print_verdict();
    end
endmodule

`default_nettype wire
